//--- inc/asc_pkg.sv
package asc_pkg;
	// register offsets, byte addresses
	localparam logic [3:0] ADDR_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_MASK = 4'h8;
	localparam logic [3:0] ADDR_STATE = 4'hc;
	// config_reg field positions
	localparam int TRIG_LSB = 0;
	localparam int PINSEL_BIT = 2;
	localparam int SWEEP_LSB = 3;
	localparam int CMODE_LSB = 5;
	localparam int SMODE_LSB = 7;
	localparam int CCLK_BIT = 9;
	localparam int CONFIG_W = 10;
	localparam logic [9:0] CONFIG_RESET = 10'h000;
	// status bits
	localparam int ST_CONV_DONE = 0;
	localparam int ST_THRESHOLD = 1;
	localparam int ST_W = 2;
	// serial clock fall counts, conversion clock count, sclk divider end
	localparam logic [5:0] SAMPLE_START_FALL = 6'h04;
	localparam logic [5:0] SHORT_END_FALL = 6'h10;
	localparam logic [5:0] LONG_END_FALL = 6'h30;
	localparam logic [4:0] CONV_CLOCKS = 5'h12;
	localparam logic [1:0] SCLK_DIV_LAST = 2'h3;
	// modes
	localparam logic [1:0] CMODE_ONE_SHOT = 2'h0;
	localparam logic [1:0] SMODE_SHORT = 2'h0;
	localparam logic [1:0] SMODE_LONG = 2'h1;
	// controller states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CMD = 4'h2,
		ST_SAMPLE = 4'h4,
		ST_CONVERT = 4'h8
	} asc_state_t;
endpackage : asc_pkg

//--- logic/asc_sampling_ctrl.sv
`timescale 1ns/10ps
module asc_sampling_ctrl
	import asc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	// serial pins, asynchronous to clk
	input wire logic sclk,
	input wire logic csN,
	input wire logic frameSync,
	// from the command decoder, same clock
	input wire logic cmdNoSample,
	input wire logic internalOscillatorTick,
	// converter control
	output logic sampling,
	output logic converting,
	output logic [1:0] chanSel,
	output logic statusPinN,
	output logic irq
);
	import asc_pkg::*;

	logic [2:0] sclkSync_q;
	logic [2:0] csSync_q;
	logic [2:0] frmSync_q;
	logic [CONFIG_W-1:0] config_q, config_d;
	logic [ST_W-1:0] status_q, status_d;
	logic [ST_W-1:0] mask_q, mask_d;
	logic [31:0] rdData_d;
	asc_state_t state_q, state_d;
	logic [5:0] fallCnt_q, fallCnt_d;
	logic [4:0] convCnt_q, convCnt_d;
	logic [1:0] div_q, div_d;
	logic [2:0] idx_q, idx_d;
	logic [1:0] chan_d;
	logic pin_q, pin_d;
	logic irq_d;
	logic sclkFall, csFall, csRise, frmRise, trigger, convTick, convEnd;
	logic [1:0] trigLevel, sweep, cMode, sMode;
	logic pinSel, cclkSel, oneShot, normalMode, lastSample;
	logic [5:0] sampleEnd;
	logic [2:0] lastIdx;

	// two-flop synchronisers; the third stage is only for edge finding
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sclkSync_q <= 3'h0;
			csSync_q <= 3'h7;
			frmSync_q <= 3'h0;
		end
		else
		begin
			sclkSync_q <= {sclkSync_q[1:0], sclk};
			csSync_q <= {csSync_q[1:0], csN};
			frmSync_q <= {frmSync_q[1:0], frameSync};
		end
	end

	// edges read stages two and three only
	assign sclkFall = sclkSync_q[2] & ~sclkSync_q[1];
	assign csFall = csSync_q[2] & ~csSync_q[1];
	assign csRise = ~csSync_q[2] & csSync_q[1];
	assign frmRise = ~frmSync_q[2] & frmSync_q[1];
	assign trigger = csFall | frmRise;

	// config fields
	assign trigLevel = config_q[TRIG_LSB +: 2];
	assign pinSel = config_q[PINSEL_BIT];
	assign sweep = config_q[SWEEP_LSB +: 2];
	assign cMode = config_q[CMODE_LSB +: 2];
	assign sMode = config_q[SMODE_LSB +: 2];
	assign cclkSel = config_q[CCLK_BIT];
	assign oneShot = (cMode == CMODE_ONE_SHOT);
	// extended mode is paced by an external trigger, not handled here
	assign normalMode = (sMode == SMODE_SHORT) || (sMode == SMODE_LONG);
	assign sampleEnd = (sMode == SMODE_LONG) ? LONG_END_FALL : SHORT_END_FALL;

	// last fifo index before the run ends
	always_comb
	begin
		unique case (trigLevel)
			2'h0: lastIdx = 3'h7;
			2'h1: lastIdx = 3'h5;
			2'h2: lastIdx = 3'h3;
			2'h3: lastIdx = 3'h1;
		endcase
	end
	assign lastSample = oneShot || (idx_q == lastIdx);

	// channel from sweep position
	always_comb
	begin
		unique case (sweep)
			2'h0: chan_d = idx_q[1:0];
			2'h1: chan_d = {idx_q[0], 1'b0};
			2'h2: chan_d = idx_q[2:1];
			2'h3: chan_d = {idx_q[2], 1'b0};
		endcase
	end

	// conversion clock: oscillator tick or every fourth sclk fall
	assign convTick = cclkSel ? (sclkFall && (div_q == SCLK_DIV_LAST)) : internalOscillatorTick;
	assign convEnd = (state_q == ST_CONVERT) && convTick && (convCnt_q == CONV_CLOCKS - 5'h1);

	// sequencer next state
	always_comb
	begin
		state_d = state_q;
		fallCnt_d = fallCnt_q;
		convCnt_d = convCnt_q;
		div_d = div_q;
		idx_d = idx_q;
		unique case (state_q)
			ST_IDLE:
			begin
				if (trigger && !cmdNoSample && normalMode)
				begin
					state_d = ST_CMD;
					fallCnt_d = 6'h0;
				end
			end
			ST_CMD:
			begin
				if (csRise || cmdNoSample)
					state_d = ST_IDLE;
				else if (trigger)
					fallCnt_d = 6'h0;
				else if (sclkFall)
				begin
					fallCnt_d = fallCnt_q + 6'h1;
					if (fallCnt_q + 6'h1 == SAMPLE_START_FALL)
						state_d = ST_SAMPLE;
				end
			end
			ST_SAMPLE:
			begin
				if (csRise)
					state_d = ST_IDLE;
				else if (trigger)
				begin
					state_d = ST_CMD;
					fallCnt_d = 6'h0;
				end
				else if (sclkFall)
				begin
					fallCnt_d = fallCnt_q + 6'h1;
					if (fallCnt_q + 6'h1 == sampleEnd)
					begin
						state_d = ST_CONVERT;
						convCnt_d = 5'h0;
						div_d = 2'h0;
					end
				end
			end
			ST_CONVERT:
			begin
				if (sclkFall)
					div_d = div_q + 2'h1;
				if (convTick)
					convCnt_d = convCnt_q + 5'h1;
				if (convEnd)
				begin
					state_d = ST_IDLE;
					idx_d = lastSample ? 3'h0 : idx_q + 3'h1;
				end
			end
		endcase
		// a new configuration restarts the sweep
		if (regWr && regAddr == ADDR_CONFIG)
			idx_d = 3'h0;
	end

	// status pin: eoc low while converting in one-shot, int low after the last conversion of a run
	always_comb
	begin
		pin_d = pin_q;
		if (pinSel && oneShot)
			pin_d = !(state_d == ST_CONVERT);
		else if (convEnd && lastSample)
			pin_d = 1'b0;
		else if (trigger || !pinSel)
			pin_d = (state_q == ST_IDLE && !trigger) ? pin_q : 1'b1;
	end

	// register next values; a set beats a write-one clear
	always_comb
	begin
		config_d = config_q;
		mask_d = mask_q;
		status_d = status_q;
		rdData_d = 32'h0;
		if (regWr && regAddr == ADDR_CONFIG)
			config_d = regWrData[CONFIG_W-1:0];
		if (regWr && regAddr == ADDR_MASK)
			mask_d = regWrData[ST_W-1:0];
		if (regWr && regAddr == ADDR_STATUS)
			status_d = status_q & ~regWrData[ST_W-1:0];
		if (convEnd)
			status_d[ST_CONV_DONE] = 1'b1;
		if (convEnd && lastSample)
			status_d[ST_THRESHOLD] = 1'b1;
		if (regRd)
		begin
			unique case (regAddr)
				ADDR_CONFIG: rdData_d = {22'h0, config_q};
				ADDR_STATUS: rdData_d = {30'h0, status_q};
				ADDR_MASK: rdData_d = {30'h0, mask_q};
				ADDR_STATE: rdData_d = {14'h0, idx_q, fallCnt_q, convCnt_q, state_q};
				default: rdData_d = 32'h0; // unmapped reads zero
			endcase
		end
		irq_d = |(status_d & mask_d);
	end

	// register stage
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			config_q <= CONFIG_RESET;
			status_q <= '0;
			mask_q <= '0;
			regRdData <= 32'h0;
			state_q <= ST_IDLE;
			fallCnt_q <= 6'h0;
			convCnt_q <= 5'h0;
			div_q <= 2'h0;
			idx_q <= 3'h0;
			pin_q <= 1'b1;
			irq <= 1'b0;
			sampling <= 1'b0;
			converting <= 1'b0;
			chanSel <= 2'h0;
		end
		else
		begin
			config_q <= config_d;
			status_q <= status_d;
			mask_q <= mask_d;
			regRdData <= rdData_d;
			state_q <= state_d;
			fallCnt_q <= fallCnt_d;
			convCnt_q <= convCnt_d;
			div_q <= div_d;
			idx_q <= idx_d;
			pin_q <= pin_d;
			irq <= irq_d;
			sampling <= (state_d == ST_SAMPLE);
			converting <= (state_d == ST_CONVERT);
			chanSel <= chan_d;
		end
	end

	assign statusPinN = pin_q;
endmodule : asc_sampling_ctrl

//--- test/asc_props.sv
`timescale 1ns/10ps
module asc_props
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// watched ports
	input wire logic regWr,
	input wire logic cmdNoSample,
	input wire logic sampling,
	input wire logic converting,
	input wire logic [1:0] chanSel,
	input wire logic statusPinN,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// sampling and conversion never overlap
	property p_excl; !(sampling && converting); endproperty
	a_excl: assert property (p_excl) else $error("sample and convert overlap");
	property p_conv; $rose(converting) |-> $past(sampling); endproperty
	a_conv: assert property (p_conv) else $error("conversion without sampling");
	// 12 serial periods are far above 8 clocks at the slowest legal rate
	property p_samp_len; $rose(sampling) |-> sampling [*8]; endproperty
	a_samp_len: assert property (p_samp_len) else $error("sampling too short");
	property p_conv_len; $rose(converting) |-> converting [*8]; endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion too short");
	property p_cmd; $rose(sampling) |-> !$past(cmdNoSample); endproperty
	a_cmd: assert property (p_cmd) else $error("sampling on blocked command");
	property p_chan; sampling && $past(sampling) |-> $stable(chanSel); endproperty
	a_chan: assert property (p_chan) else $error("channel moved in sampling");
	property p_pin;
		$fell(statusPinN) |-> converting || $past(converting) || $past(converting, 2);
	endproperty
	a_pin: assert property (p_pin) else $error("status pin fell off conversion");
	property p_irq;
		$rose(irq) |-> $past(converting, 2) || $past(regWr) || $past(regWr, 2);
	endproperty
	a_irq: assert property (p_irq) else $error("irq rose without cause");
	c_samp: cover property ($rose(sampling));
	c_conv: cover property ($fell(converting));
	c_irq: cover property ($rose(irq));
endmodule : asc_props

//--- test/asc_host_model.sv
`timescale 1ns/10ps
module asc_host_model
(
	// serial pins
	output logic sclk,
	output logic csN,
	output logic frameSync
);
	int falls = 0;
	initial
	begin
		sclk = 1'b0;
		csN = 1'b1;
		frameSync = 1'b0;
	end
	// one frame; the clock stands still between frames
	task automatic frame(input logic useFrame, input int n);
		falls = 0;
		csN = useFrame;
		frameSync = useFrame;
		#100;
		frameSync = 1'b0;
		repeat (n)
		begin
			sclk = 1'b1;
			#100;
			sclk = 1'b0;
			falls++;
			#100;
		end
		csN = 1'b1;
		#400;
	endtask : frame
endmodule : asc_host_model

//--- test/testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %0h seen %0h", n, e, g); end end
module testbench;
	import asc_pkg::*;
	logic clk = 0, resetn = 0, regWr = 0, regRd = 0, cmdNoSample = 0, internalOscillatorTick = 0;
	logic [3:0] regAddr = 0;
	logic [31:0] regWrData = 0, regRdData;
	logic sclk, csN, frameSync, sampling, converting, statusPinN, irq, samp_q, conv_q;
	logic [1:0] chanSel, chanAtSamp;
	int failures = 0, checks = 0, cyc = 0, sampFall, convFall, endFall, convTicks;
	asc_host_model host (.sclk(sclk), .csN(csN), .frameSync(frameSync));
	asc_sampling_ctrl DUT (.clk(clk), .resetn(resetn), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.sclk(sclk), .csN(csN), .frameSync(frameSync), .cmdNoSample(cmdNoSample),
		.internalOscillatorTick(internalOscillatorTick), .sampling(sampling),
		.converting(converting),
		.chanSel(chanSel), .statusPinN(statusPinN), .irq(irq));
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	// oscillator tick every fourth cycle, serial fall count at each start, hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		internalOscillatorTick <= (cyc % 4 == 0);
		samp_q <= sampling;
		conv_q <= converting;
		// both seen as the design sees them at this edge
		if (converting && internalOscillatorTick)
			convTicks++;
		if (!converting && conv_q)
			endFall = host.falls;
		if (sampling && !samp_q)
		begin
			sampFall = host.falls;
			chanAtSamp = chanSel;
		end
		if (converting && !conv_q)
			convFall = host.falls;
		if (cyc == 20000)
		begin
			failures++;
			end_of_test();
		end
	end
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 `CHK("read data", e, regRdData)
	endtask : rd
	// one frame, then wait out any conversion it started
	task automatic run(input logic useFrame, input int n, input int s, input int c, input logic pin);
		sampFall = 0;
		convFall = 0;
		convTicks = 0;
		host.frame(useFrame, n);
		`CHK("sample fall", s, sampFall)
		`CHK("convert fall", c, convFall)
		if (c != 0) `CHK("pin in conversion", pin, statusPinN)
		for (int i = 0; i < 400 && converting; i++) @(posedge clk);
		@(posedge clk);
		#1;
		if (c != 0) `CHK("conversion clocks", 18, convTicks)
	endtask : run
	task automatic t_oneshot;
		wr(ADDR_MASK, 32'h1);
		wr(ADDR_CONFIG, 32'h4);
		run(1'b0, 20, 4, 16, 1'b0);
		`CHK("irq", 1'b1, irq)
		`CHK("pin after", 1'b1, statusPinN)
		wr(ADDR_STATUS, 32'h3);
		@(posedge clk);
		#1 `CHK("irq clear", 1'b0, irq)
	endtask : t_oneshot
	task automatic t_long;
		wr(ADDR_CONFIG, 32'h83);
		run(1'b1, 50, 4, 48, 1'b1);
		`CHK("int pin", 1'b0, statusPinN)
		rd(ADDR_STATUS, 32'h3);
	endtask : t_long
	task automatic t_refuse;
		@(posedge clk);
		cmdNoSample <= 1'b1;
		run(1'b0, 20, 0, 0, 1'b1);
		@(posedge clk);
		cmdNoSample <= 1'b0;
		wr(ADDR_CONFIG, 32'h100);
		run(1'b0, 20, 0, 0, 1'b1);
		wr(ADDR_CONFIG, 32'h0);
		host.frame(1'b0, 2);
		run(1'b0, 20, 4, 16, 1'b1);
	endtask : t_refuse
	// one sweep of n conversions, channel order packed two bits each
	task automatic sweep_run(input logic [31:0] cfg, input int n, input logic [15:0] seq);
		wr(ADDR_STATUS, 32'h3);
		wr(ADDR_CONFIG, cfg);
		for (int k = 0; k < n; k++)
		begin
			run(1'b0, 20, 4, 16, 1'b1);
			`CHK("sweep channel", seq[2*k+:2], chanAtSamp)
			rd(ADDR_STATUS, {30'h0, k == n - 1, 1'b1});
		end
	endtask : sweep_run
	// every sweep order, every trigger level
	task automatic t_sweep;
		sweep_run(32'h52, 4, 16'h0050);
		sweep_run(32'h59, 6, 16'h0a00);
		sweep_run(32'h40, 8, 16'he4e4);
		sweep_run(32'h4b, 2, 16'h0008);
	endtask : t_sweep
	// conversion clocked by every fourth serial fall
	task automatic t_sclkconv;
		wr(ADDR_CONFIG, 32'h200);
		sampFall = 0;
		convFall = 0;
		endFall = 0;
		host.frame(1'b0, 90);
		`CHK("sample fall", 4, sampFall)
		`CHK("convert fall", 16, convFall)
		`CHK("sclk conversion end", 88, endFall)
	endtask : t_sclkconv
	task automatic end_of_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(ADDR_CONFIG, 32'h0);
		rd(4'h2, 32'h0);
		t_oneshot();
		t_long();
		t_refuse();
		t_sweep();
		t_sclkconv();
		end_of_test();
	end
endmodule : testbench
bind asc_sampling_ctrl asc_props chk (.clk(clk), .resetn(resetn), .regWr(regWr),
	.cmdNoSample(cmdNoSample), .sampling(sampling), .converting(converting),
	.chanSel(chanSel), .statusPinN(statusPinN), .irq(irq));
